// file: swl_pkg.sv
// Operation
// - The receiver takes one character from the shared line and presents the assembled byte as received data.
// - Both ends use NRZ signalling with the same character format and baud rate as the monitor serial link.
// - One bit period lasts 256 operating clocks, so the baud rate is the clock divided by 256.
// - The transmitter uses the same bit period and character format as the receiver.
// - A missing stop bit at the end of a character is detected as a framing error.
// - On completion a carry flag reports 1 for a good stop bit and 0 for a framing error.
// - Once receive is requested the receiver waits without limit for a low start bit, then finishes at the middle of the stop bit.
// - After a send the holding value and index register are unchanged and the pin is back to input with latch zero.
// - Neither service touches the operating watchdog during a transfer.
package swl_pkg;

   localparam int unsigned BIT_CLKS      = 256;
   localparam int unsigned HALF_CLKS     = BIT_CLKS / 2;
   localparam int unsigned DATA_BITS     = 8;

   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_STATUS   = 12'h004;
   localparam logic [11:0] ADDR_TXDATA   = 12'h008;
   localparam logic [11:0] ADDR_RXDATA   = 12'h00C;
   localparam logic [11:0] ADDR_INDEX    = 12'h010;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h014;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;

   localparam int unsigned CTRL_RX_GO    = 0;
   localparam int unsigned CTRL_TX_GO    = 1;
   localparam int unsigned ST_RX_BUSY    = 0;
   localparam int unsigned ST_TX_BUSY    = 1;
   localparam int unsigned ST_CARRY      = 2;
   localparam int unsigned IRQ_RX_DONE   = 0;
   localparam int unsigned IRQ_TX_DONE   = 1;
   localparam int unsigned IRQ_FRAME_ERR = 2;

   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   localparam logic [2:0]  IRQ_RESET     = 3'h0;
   localparam logic [7:0]  BYTE_RESET    = 8'h00;

   typedef struct packed {
      logic       done;
      logic       carry;
      logic [7:0] data;
   } swl_rx_result_s;

endpackage : swl_pkg

// file: swl_rx.sv
`timescale 1ns/1ps
`default_nettype none
module swl_rx
   import swl_pkg::*;
(
   input  wire logic     clk_sys_i,    // Operating clock
   input  wire logic     arst_n_i,     // Async reset, active low
   input  wire logic     go_i,         // Arm the receiver, one pulse
   input  wire logic     line_i,       // Synchronised line level
   output logic          busy_o,       // Armed or receiving
   output swl_rx_result_s res_o        // Completion pulse, carry, byte
);
   typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_SHIFT} swl_rx_state_e;

   swl_rx_state_e state_reg;
   logic [8:0]    cnt_reg;
   logic [3:0]    bit_reg;
   logic [7:0]    sh_reg;
   logic          tick;
   logic          last_bit;

   // Middle of start bit after half a period, then one full period apart
   assign tick     = (cnt_reg == 9'(BIT_CLKS - 1));
   assign last_bit = (bit_reg == 4'(DATA_BITS));
   assign busy_o   = (state_reg != RX_IDLE);

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state_reg <= RX_IDLE;
         cnt_reg   <= 9'h000;
         bit_reg   <= 4'h0;
         sh_reg    <= BYTE_RESET;
         res_o     <= '0;
      end
      else
      begin
         res_o.done <= 1'b0;
         case (state_reg)
            RX_IDLE:
               if (go_i)
                  state_reg <= RX_HUNT;
            RX_HUNT:
               // Waits without limit; no watchdog kick here
               if (!line_i)
               begin
                  state_reg <= RX_SHIFT;
                  cnt_reg   <= 9'(HALF_CLKS);
                  bit_reg   <= 4'hF;
               end
            RX_SHIFT:
               if (tick)
               begin
                  cnt_reg <= 9'h000;
                  bit_reg <= bit_reg + 4'h1;
                  if (bit_reg == 4'hF && line_i)
                     state_reg <= RX_HUNT;    // Glitch, not a start bit
                  else if (last_bit)
                  begin
                     state_reg   <= RX_IDLE;
                     res_o.done  <= 1'b1;
                     res_o.data  <= sh_reg;
                     res_o.carry <= line_i;
                  end
                  else if (bit_reg != 4'hF)
                     sh_reg <= {line_i, sh_reg[7:1]};
               end
               else
                  cnt_reg <= cnt_reg + 9'h001;
            default:
               state_reg <= RX_IDLE;
         endcase
      end
   end
endmodule : swl_rx
`default_nettype wire

// file: swl_tx.sv
`timescale 1ns/1ps
`default_nettype none
module swl_tx
   import swl_pkg::*;
(
   input  wire logic       clk_sys_i,  // Operating clock
   input  wire logic       arst_n_i,   // Async reset, active low
   input  wire logic       go_i,       // Start a send, one pulse
   input  wire logic [7:0] data_i,     // Holding register value
   output logic            busy_o,     // Sending
   output logic            done_o,     // Send finished, one pulse
   output logic            pull_low_o  // Direction bit: 1 drives low
);
   logic [8:0] cnt_reg;
   logic [3:0] bit_reg;
   logic [9:0] frame_reg;
   logic       tick;

   assign tick = (cnt_reg == 9'(BIT_CLKS - 1));

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         busy_o     <= 1'b0;
         done_o     <= 1'b0;
         cnt_reg    <= 9'h000;
         bit_reg    <= 4'h0;
         frame_reg  <= '1;
         pull_low_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (!busy_o && go_i)
         begin
            busy_o    <= 1'b1;
            cnt_reg   <= 9'h000;
            bit_reg   <= 4'h0;
            // Own copy so the holding register is never disturbed
            frame_reg  <= {1'b1, data_i, 1'b0};
            pull_low_o <= 1'b1;
         end
         else if (busy_o)
         begin
            if (tick)
            begin
               cnt_reg <= 9'h000;
               if (bit_reg == 4'(DATA_BITS + 1))
               begin
                  busy_o     <= 1'b0;
                  done_o     <= 1'b1;
                  pull_low_o <= 1'b0;
               end
               else
               begin
                  bit_reg    <= bit_reg + 4'h1;
                  frame_reg  <= {1'b1, frame_reg[9:1]};
                  // Only direction switches; a one is left to the pull-up
                  pull_low_o <= ~frame_reg[1];
               end
            end
            else
               cnt_reg <= cnt_reg + 9'h001;
         end
      end
   end
endmodule : swl_tx
`default_nettype wire

// file: swl_link.sv
`timescale 1ns/1ps
`default_nettype none
module swl_link
   import swl_pkg::*;
(
   input  wire logic        clk_sys_i,      // 100 MHz operating clock
   input  wire logic        arst_n_i,       // Async reset, active low
   input  wire logic [11:0] s_axi_awaddr,   // Write address
   input  wire logic        s_axi_awvalid,  // Write address valid
   output logic             s_axi_awready,  // Write address ready
   input  wire logic [31:0] s_axi_wdata,    // Write data
   input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
   input  wire logic        s_axi_wvalid,   // Write data valid
   output logic             s_axi_wready,   // Write data ready
   output logic [1:0]       s_axi_bresp,    // Write response
   output logic             s_axi_bvalid,   // Write response valid
   input  wire logic        s_axi_bready,   // Write response ready
   input  wire logic [11:0] s_axi_araddr,   // Read address
   input  wire logic        s_axi_arvalid,  // Read address valid
   output logic             s_axi_arready,  // Read address ready
   output logic [31:0]      s_axi_rdata,    // Read data
   output logic [1:0]       s_axi_rresp,    // Read response
   output logic             s_axi_rvalid,   // Read data valid
   input  wire logic        s_axi_rready,   // Read data ready
   input  wire logic        line_i,         // Shared serial line level
   output logic             line_o,         // Pin data latch, always 0
   output logic             line_oe_o,      // Direction bit, 1 = drive
   output logic             irq_o           // Level interrupt
);
   // ---------------------------------------------------------------
   // Line synchroniser
   // ---------------------------------------------------------------
   logic sync1_reg;
   logic sync2_reg;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end
      else
      begin
         sync1_reg <= line_i;
         sync2_reg <= sync1_reg;
      end
   end

   // ---------------------------------------------------------------
   // AXI4-Lite write path
   // ---------------------------------------------------------------
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic [11:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        wr_fire;
   logic        wr_ctrl;
   logic        wr_txd;
   logic        wr_idx;
   logic        wr_istat;
   logic        wr_imask;
   logic        wr_known;

   assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
   assign wr_fire  = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
   assign wr_ctrl  = wr_fire && (awaddr_reg == ADDR_CTRL) && wstrb_reg[0];
   assign wr_txd   = wr_fire && (awaddr_reg == ADDR_TXDATA) && wstrb_reg[0];
   assign wr_idx   = wr_fire && (awaddr_reg == ADDR_INDEX) && wstrb_reg[0];
   assign wr_istat = wr_fire && (awaddr_reg == ADDR_IRQ_STAT)
                     && wstrb_reg[0];
   assign wr_imask = wr_fire && (awaddr_reg == ADDR_IRQ_MASK)
                     && wstrb_reg[0];
   assign wr_known = (awaddr_reg == ADDR_CTRL)
                  || (awaddr_reg == ADDR_STATUS)
                  || (awaddr_reg == ADDR_TXDATA)
                  || (awaddr_reg == ADDR_RXDATA)
                  || (awaddr_reg == ADDR_INDEX)
                  || (awaddr_reg == ADDR_IRQ_STAT)
                  || (awaddr_reg == ADDR_IRQ_MASK);

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         aw_hold_reg  <= 1'b0;
         w_hold_reg   <= 1'b0;
         awaddr_reg   <= 12'h000;
         wdata_reg    <= 32'h0000_0000;
         wstrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= {s_axi_awaddr[11:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Registers and engines
   // ---------------------------------------------------------------
   logic [7:0]     txdata_reg;
   logic [7:0]     index_reg;
   logic [7:0]     rxdata_reg;
   logic           carry_reg;
   logic [2:0]     istat_reg;
   logic [2:0]     imask_reg;
   logic           rx_busy;
   logic           tx_busy;
   logic           tx_done;
   logic           rx_go;
   logic           tx_go;
   logic [2:0]     ev;
   swl_rx_result_s rx_res;

   // One transfer at a time on a half-duplex wire
   assign rx_go = wr_ctrl && wdata_reg[CTRL_RX_GO] && !rx_busy && !tx_busy;
   assign tx_go = wr_ctrl && wdata_reg[CTRL_TX_GO] && !wdata_reg[CTRL_RX_GO]
                  && !rx_busy && !tx_busy;

   swl_rx u_rx
   (
      .clk_sys_i (clk_sys_i),
      .arst_n_i  (arst_n_i),
      .go_i      (rx_go),
      .line_i    (sync2_reg),
      .busy_o    (rx_busy),
      .res_o     (rx_res)
   );

   swl_tx u_tx
   (
      .clk_sys_i  (clk_sys_i),
      .arst_n_i   (arst_n_i),
      .go_i       (tx_go),
      .data_i     (txdata_reg),
      .busy_o     (tx_busy),
      .done_o     (tx_done),
      .pull_low_o (line_oe_o)
   );

   // Open-drain: latch stays zero, only the direction moves
   assign line_o = 1'b0;

   assign ev[IRQ_RX_DONE]   = rx_res.done;
   assign ev[IRQ_TX_DONE]   = tx_done;
   assign ev[IRQ_FRAME_ERR] = rx_res.done && !rx_res.carry;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         txdata_reg <= BYTE_RESET;
         index_reg  <= BYTE_RESET;
         rxdata_reg <= BYTE_RESET;
         carry_reg  <= 1'b0;
         istat_reg  <= IRQ_RESET;
         imask_reg  <= IRQ_RESET;
      end
      else
      begin
         // Writes to TXDATA and INDEX while sending are ignored so sends see a stable byte
         if (wr_txd && !tx_busy)
            txdata_reg <= wdata_reg[7:0];
         if (wr_idx && !tx_busy)
            index_reg <= wdata_reg[7:0];
         if (rx_res.done)
         begin
            rxdata_reg <= rx_res.data;
            carry_reg  <= rx_res.carry;
         end
         if (wr_imask)
            imask_reg <= wdata_reg[2:0];
         // Set beats clear in the same cycle
         istat_reg <= (istat_reg & ~(wr_istat ? wdata_reg[2:0] : 3'h0)) | ev;
      end
   end

   // Transfers never gate the interrupt themselves
   assign irq_o = |(istat_reg & imask_reg);

   // ---------------------------------------------------------------
   // AXI4-Lite read path
   // ---------------------------------------------------------------
   logic [11:0] ra;
   logic        rd_known;
   logic [31:0] rd_mux;

   assign s_axi_arready = !s_axi_rvalid;
   assign ra = {s_axi_araddr[11:2], 2'b00};
   assign rd_known = (ra == ADDR_CTRL) || (ra == ADDR_STATUS)
                  || (ra == ADDR_TXDATA) || (ra == ADDR_RXDATA)
                  || (ra == ADDR_INDEX) || (ra == ADDR_IRQ_STAT)
                  || (ra == ADDR_IRQ_MASK);
   assign rd_mux =
        (ra == ADDR_STATUS)   ? {29'h0, carry_reg, tx_busy, rx_busy}
      : (ra == ADDR_TXDATA)   ? {24'h0, txdata_reg}
      : (ra == ADDR_RXDATA)   ? {24'h0, rxdata_reg}
      : (ra == ADDR_INDEX)    ? {24'h0, index_reg}
      : (ra == ADDR_IRQ_STAT) ? {29'h0, istat_reg}
      : (ra == ADDR_IRQ_MASK) ? {29'h0, imask_reg}
      : 32'h0000_0000;

   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_mux;
         s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule : swl_link
`default_nettype wire

// file: swl_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module swl_link_monitor
   import swl_pkg::*;
(
   input wire logic        clk_sys_i,     // Clock
   input wire logic        arst_n_i,      // Reset, active low
   input wire logic        s_axi_awvalid, // Write address valid
   input wire logic        s_axi_awready, // Write address ready
   input wire logic        s_axi_wvalid,  // Write data valid
   input wire logic        s_axi_wready,  // Write data ready
   input wire logic [1:0]  s_axi_bresp,   // Write response
   input wire logic        s_axi_bvalid,  // Write response valid
   input wire logic        s_axi_bready,  // Write response ready
   input wire logic [11:0] s_axi_araddr,  // Read address
   input wire logic        s_axi_arvalid, // Read address valid
   input wire logic        s_axi_arready, // Read address ready
   input wire logic [31:0] s_axi_rdata,   // Read data
   input wire logic [1:0]  s_axi_rresp,   // Read response
   input wire logic        s_axi_rvalid,  // Read data valid
   input wire logic        s_axi_rready,  // Read data ready
   input wire logic        line_o,        // Pin data latch
   input wire logic        line_oe_o      // Pin direction
);
   // ----------------------------------------
   // Length of the current drive run
   // ----------------------------------------
   logic        oe_q;
   logic [11:0] run_q;
   always_ff @(posedge clk_sys_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         oe_q  <= 1'b0;
         run_q <= 12'h000;
      end
      else
      begin
         oe_q  <= line_oe_o;
         run_q <= (line_oe_o != oe_q) ? 12'h001 : run_q + 12'h001;
      end
   end

   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);

   chk_latch_low: assert property (line_o == 1'b0)
      else $error("pin data latch not zero");
   chk_bit_whole: assert property (oe_q && !line_oe_o |-> run_q[7:0] == 8'h00)
      else $error("low run not whole bit periods");
   chk_frame_len: assert property (oe_q && !line_oe_o |-> run_q <= 12'h900)
      else $error("low run longer than start plus data");
   chk_write_resp: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
      else $error("write response late");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid)
      else $error("read data late");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_map_ok: assert property (s_axi_arvalid && s_axi_arready &&
      {s_axi_araddr[11:2], 2'b00} <= ADDR_IRQ_MASK |=>
      s_axi_rresp == RESP_OKAY)
      else $error("mapped read refused");
   chk_map_err: assert property (s_axi_arvalid && s_axi_arready &&
      {s_axi_araddr[11:2], 2'b00} > ADDR_IRQ_MASK |=>
      s_axi_rresp == RESP_SLVERR &&
      s_axi_rdata == 32'h0)
      else $error("unmapped read accepted");
endmodule : swl_link_monitor

bind swl_link swl_link_monitor i_mon (.*);
`default_nettype wire

// file: swl_host.sv
`timescale 1ns/1ps
`default_nettype none
module swl_host
   import swl_pkg::*;
(
   input  wire logic clk_sys_i, // Operating clock
   input  wire logic line_i,    // Resolved line level
   output var logic  pull_o     // 1 pulls the line low
);
   logic [7:0] hb;
   logic [8:0] rx_q [$];
   initial pull_o = 1'b0;
   // ----------------------------------------
   // Send: only ever pulls low, ones come from the pull-up
   // ----------------------------------------
   task automatic send(input logic [7:0] d, input bit ok, input int glitch);
      logic [9:0] f;
      f = {ok, d, 1'b0};
      if (glitch > 0)
      begin
         pull_o <= 1'b1;
         repeat (glitch) @(posedge clk_sys_i);
         pull_o <= 1'b0;
         repeat (300) @(posedge clk_sys_i);
      end
      for (int i = 0; i < 10; i++)
      begin
         pull_o <= !f[i];
         repeat (BIT_CLKS) @(posedge clk_sys_i);
      end
      pull_o <= 1'b0;
      repeat (BIT_CLKS) @(posedge clk_sys_i);
   endtask : send
   // Listen only to frames the host did not start itself
   always
   begin
      @(negedge line_i iff !pull_o);
      repeat (HALF_CLKS) @(posedge clk_sys_i);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BIT_CLKS) @(posedge clk_sys_i);
         hb[i] = line_i;
      end
      repeat (BIT_CLKS) @(posedge clk_sys_i);
      rx_q.push_back({line_i, hb});
   end
endmodule : swl_host
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import swl_pkg::*;
   logic        clk_sys_i, arst_n_i, host_pull, m_busy, stp;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, s;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, line_o, line_oe_o, irq_o;
   logic [7:0]  b, x;
   int unsigned mreg [8];
   int          n_errors = 0, num_checks = 0, cyc = 0;
   // Both parties only pull low against the pull-up
   wire         line_w = (line_oe_o ? line_o : 1'b1) & !host_pull;

   swl_link i_dut (.*, .line_i(line_w));
   swl_host i_host (.clk_sys_i(clk_sys_i), .line_i(line_w),
                    .pull_o(host_pull));

   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      bit ap, wp;
      ap = 1'b1;
      wp = 1'b1;
      @(posedge clk_sys_i);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (ap || wp)
      begin
         @(posedge clk_sys_i);
         if (ap && s_axi_awready)
         begin
            ap = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (wp && s_axi_wready)
         begin
            wp = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge clk_sys_i);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, (a > ADDR_IRQ_MASK) ? RESP_SLVERR : RESP_OKAY);
      if (a == ADDR_IRQ_STAT) mreg[5] &= ~d;
      else if (a == ADDR_IRQ_MASK) mreg[6] = d & 7;
      else if ((a == ADDR_TXDATA || a == ADDR_INDEX) && !m_busy)
         mreg[a[4:2]] = d & 8'hFF;
   endtask : wr

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge clk_sys_i);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge clk_sys_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      while (!s_axi_rvalid) @(posedge clk_sys_i);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk(s_axi_rresp, (a > ADDR_IRQ_MASK) ? RESP_SLVERR : RESP_OKAY);
   endtask : rd

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask : rd_chk

   task automatic idle;
      logic [31:0] st;
      do rd(ADDR_STATUS, st); while (st[1:0] !== 2'b00);
   endtask : idle

   task automatic results;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : results

   // Cut a hung run short; the tests need about 18000 cycles
   always @(posedge clk_sys_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 80000)
      begin
         n_errors++;
         results();
      end
   end

   initial
   begin
      {arst_n_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
      {s_axi_arvalid, s_axi_rready, m_busy} = 3'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (16) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      void'($urandom(31));
      for (int a = 0; a < 32; a += 4)
         if (a != 4) rd_chk(a[11:0], mreg[a / 4]);
      // Unmapped write must be refused with an error response
      wr(12'h01C, 32'h0000_0000);
      // ----------------------------------------
      // Send: edge bytes and a random one
      // ----------------------------------------
      wr(ADDR_IRQ_MASK, 32'h7);
      for (int k = 0; k < 3; k++)
      begin
         b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
         x = 8'($urandom);
         wr(ADDR_INDEX, x);
         wr(ADDR_TXDATA, b);
         wr(ADDR_CTRL, 32'h2);
         m_busy = 1'b1;
         rd(ADDR_STATUS, s);
         chk(s[1:0], 2'h2);
         wr(ADDR_TXDATA, ~b);
         idle();
         m_busy = 1'b0;
         mreg[5] |= 2;
         chk(i_host.rx_q.size(), 1);
         chk(i_host.rx_q.pop_front(), {1'b1, b});
         rd_chk(ADDR_TXDATA, mreg[2]);
         rd_chk(ADDR_INDEX, mreg[4]);
         chk(line_oe_o, 1'b0);
         chk(irq_o, 1'b1);
         wr(ADDR_IRQ_STAT, 32'h7);
         chk(irq_o, 1'b0);
      end
      // ----------------------------------------
      // Receive: masked, framing error, glitch
      // ----------------------------------------
      for (int k = 0; k < 3; k++)
      begin
         stp = (k != 1);
         b = 8'($urandom);
         wr(ADDR_IRQ_MASK, (k == 0) ? 32'h0 : 32'h7);
         wr(ADDR_CTRL, 32'h1);
         repeat ($urandom_range(600, 50)) @(posedge clk_sys_i);
         i_host.send(b, stp, (k == 2) ? 40 : 0);
         idle();
         mreg[3] = b;
         mreg[5] |= stp ? 1 : 5;
         rd_chk(ADDR_RXDATA, mreg[3]);
         rd_chk(ADDR_STATUS, stp ? 4 : 0);
         rd_chk(ADDR_IRQ_STAT, mreg[5]);
         chk(irq_o, (mreg[5] & mreg[6]) != 0);
         wr(ADDR_IRQ_MASK, 32'h7);
         chk(irq_o, 1'b1);
         wr(ADDR_IRQ_STAT, 32'h7);
         chk(irq_o, 1'b0);
      end
      results();
   end
endmodule : testbench
`default_nettype wire
